// file: rtl/src_regs.svh
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH

// register offsets (byte addresses)
`define SRC_ADDR_CAUSE 8'h00
`define SRC_ADDR_SWTRIG 8'h04
`define SRC_ADDR_IRQ_STATUS 8'h08
`define SRC_ADDR_IRQ_MASK 8'h0C

// reset_cause_control field positions
`define SRC_BIT_CMR 9
`define SRC_BIT_VREG 8
`define SRC_BIT_EXT 7
`define SRC_BIT_SWR 6
`define SRC_BIT_GAP 5
`define SRC_BIT_WDT 4
`define SRC_BIT_SLEEP 3
`define SRC_BIT_IDLE 2
`define SRC_BIT_BOR 1
`define SRC_BIT_POR 0
`define SRC_BIT_TRIG 0

// reset values and write masks
`define SRC_CAUSE_RESET 10'h003
`define SRC_CAUSE_WMASK 10'h3DF
`define SRC_IRQ_WMASK 10'h2DF
`define SRC_IRQ_RESET 10'h000
`define SRC_ZERO_WORD 32'h0000_0000

// master reset stretch after the last cause goes away
`define SRC_HOLD_CYCLES 5'h10
`define SRC_CNT_ONE 5'h01
`define SRC_CNT_ZERO 5'h00

`endif

// file: rtl/src_pkg.sv
package src_pkg;

	typedef enum logic [2:0] {
		SRC_ST_RUN = 3'b001,
		SRC_ST_CAUSE = 3'b010,
		SRC_ST_HOLD = 3'b100
	} src_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic write;
		logic read;
	} src_bus_req_t;

	// level causes stay asserted (the pin low) while the detector holds reset; wake flags are pulses
	typedef struct packed {
		logic external_clear_pin_n;
		logic watchdog_timeout;
		logic brownout;
		logic config_mismatch;
		logic sleep_wake;
		logic idle_wake;
	} src_causes_t;

	typedef struct packed {
		src_state_t state;
		logic [4:0] hold_cnt;
		logic [9:0] cause;
		logic [9:0] irq_status;
		logic [9:0] irq_mask;
		logic [3:0] prev_level;
		logic sw_pending;
		logic master_system_reset;
		logic regulator_sleep_keep_on;
		logic irq;
		logic [31:0] rdata;
	} src_state_s_t;

endpackage

// file: rtl/src_reset_ctrl.sv
// Added by the designer: the placing of the registers and strobed register access.
`include "src_regs.svh"

// Overview of operation
// R01 - merge five causes into one master reset
// R02 - hardware sets mismatch flag, bit 9
// R03 - bit 8 keeps regulator on in sleep
// R04 - hardware sets external pin flag, bit 7
// R05 - hardware sets software reset flag, bit 6
// R06 - hardware sets watchdog timeout flag, bit 4
// R07 - hardware sets wake from sleep flag
// R08 - hardware sets wake from idle flag
// R09 - brownout flag set by hardware, one at power-on
// R10 - power-on flag set, one at power-on
// R11 - software clears brownout and power-on flags
// R12 - cause register upper bits and bit 5 read zero
// R13 - trigger one starts reset, hardware clears
// R14 - trigger ignored unless system unlocked
// R15 - trigger register reads all zero
// R16 - cause flags survive non power-on resets
// R17 - software writes flags, hardware set wins
module src_reset_ctrl (
	input wire logic clk_sys,
	input wire logic reset_n,
	input src_pkg::src_causes_t causes,
	input wire logic system_unlocked,
	input src_pkg::src_bus_req_t bus,
	output logic [31:0] reg_rdata,
	output logic master_system_reset,
	output logic regulator_sleep_keep_on,
	output logic irq
);
	import src_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// decoding

	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		reg_hit = (addr == offset);
	endfunction

	// rising edge of a level against its value on the last edge
	function automatic logic level_rose(
		input logic now_level,
		input logic last_level
	);
		level_rose = now_level & ~last_level;
	endfunction

	// one sticky bit: a set in the same cycle beats a clear
	function automatic logic sticky_bit(
		input logic held,
		input logic clear_now,
		input logic set_now
	);
		sticky_bit = set_now | (held & ~clear_now);
	endfunction

	// read mux; only bits 9:0 exist, everything above reads as zero
	function automatic logic [31:0] read_word(
		input logic [7:0] addr,
		input logic [9:0] cause,
		input logic [9:0] irq_status,
		input logic [9:0] irq_mask
	);
		read_word = `SRC_ZERO_WORD; // R15
		if (reg_hit(addr, `SRC_ADDR_CAUSE)) begin
			read_word[9:0] = cause; // R12
		end else if (reg_hit(addr, `SRC_ADDR_IRQ_STATUS)) begin
			read_word[9:0] = irq_status;
		end else if (reg_hit(addr, `SRC_ADDR_IRQ_MASK)) begin
			read_word[9:0] = irq_mask;
		end
		// the trigger register is write-only and holes in the map read zero
	endfunction

	localparam src_state_s_t SRC_POR_STATE = '{
		state: SRC_ST_CAUSE,
		hold_cnt: `SRC_HOLD_CYCLES,
		cause: `SRC_CAUSE_RESET,
		irq_status: `SRC_IRQ_RESET,
		irq_mask: `SRC_IRQ_RESET,
		prev_level: 4'h0,
		sw_pending: 1'b0,
		master_system_reset: 1'b1,
		regulator_sleep_keep_on: 1'b0,
		irq: 1'b0,
		rdata: `SRC_ZERO_WORD
	};

	src_state_s_t st;
	src_state_s_t next_st;

	logic [3:0] level_now;
	logic any_level;
	logic [9:0] hw_set;
	logic [9:0] irq_event;
	logic wr_cause;
	logic wr_trig;
	logic wr_ist;
	logic wr_imk;
	logic [9:0] wdata10;
	logic [3:0] level_rise;
	logic [9:0] next_cause_bits;
	logic [9:0] irq_set;
	logic [9:0] next_irq_bits;
	logic trig_accept;

	// write masks as vectors so the bit loops can index them
	localparam logic [9:0] CAUSE_WMASK = `SRC_CAUSE_WMASK;
	localparam logic [9:0] IRQ_WMASK = `SRC_IRQ_WMASK;

	////////////////////////////////////////////////////////////////////////////////
	// cause detection

	// level causes in one vector, the pin on top
	assign level_now = {~causes.external_clear_pin_n, causes.watchdog_timeout,
		causes.brownout, causes.config_mismatch};

	// edges against the last level, so a held cause interrupts only once
	for (genvar g = 0; g < 4; g++) begin : g_rise
		assign level_rise[g] = level_rose(level_now[g], st.prev_level[g]);
	end

	always_comb begin
		any_level = |level_now; // R01
		hw_set = 10'h000;
		hw_set[`SRC_BIT_CMR] = causes.config_mismatch; // R02
		hw_set[`SRC_BIT_EXT] = ~causes.external_clear_pin_n; // R04
		hw_set[`SRC_BIT_SWR] = st.sw_pending; // R05
		hw_set[`SRC_BIT_WDT] = causes.watchdog_timeout; // R06
		hw_set[`SRC_BIT_SLEEP] = causes.sleep_wake; // R07
		hw_set[`SRC_BIT_IDLE] = causes.idle_wake; // R08
		hw_set[`SRC_BIT_BOR] = causes.brownout; // R09
		// interrupt events: rising edges of level causes plus the pulse causes
		irq_event = 10'h000;
		irq_event[`SRC_BIT_EXT] = level_rise[3];
		irq_event[`SRC_BIT_WDT] = level_rise[2];
		irq_event[`SRC_BIT_BOR] = level_rise[1];
		irq_event[`SRC_BIT_CMR] = level_rise[0];
		irq_event[`SRC_BIT_SWR] = st.sw_pending;
		irq_event[`SRC_BIT_SLEEP] = causes.sleep_wake;
		irq_event[`SRC_BIT_IDLE] = causes.idle_wake;
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes

	always_comb begin
		wdata10 = bus.wdata[9:0];
		wr_cause = bus.write & reg_hit(bus.addr, `SRC_ADDR_CAUSE);
		wr_trig = bus.write & reg_hit(bus.addr, `SRC_ADDR_SWTRIG);
		wr_ist = bus.write & reg_hit(bus.addr, `SRC_ADDR_IRQ_STATUS);
		wr_imk = bus.write & reg_hit(bus.addr, `SRC_ADDR_IRQ_MASK);
		trig_accept = wr_trig & wdata10[`SRC_BIT_TRIG] & system_unlocked; // R13 R14
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-bit flag update

	// cause flags are plain read/write; a hardware set beats a software clear
	for (genvar g = 0; g < 10; g++) begin : g_cause
		assign next_cause_bits[g] = CAUSE_WMASK[g] & ((wr_cause ? wdata10[g] : st.cause[g]) | hw_set[g]); // R17 R12
	end

	// sticky status, write one to clear; only event positions can ever set
	for (genvar g = 0; g < 10; g++) begin : g_irq
		assign irq_set[g] = irq_event[g] & IRQ_WMASK[g];
		assign next_irq_bits[g] = sticky_bit(st.irq_status[g], wr_ist & wdata10[g], irq_set[g]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		next_st.prev_level = level_now;

		next_st.cause = next_cause_bits; // R17
		next_st.cause[`SRC_BIT_GAP] = 1'b0; // R12
		next_st.irq_status = next_irq_bits;
		if (wr_imk) begin
			next_st.irq_mask = wdata10 & `SRC_IRQ_WMASK;
		end
		next_st.irq = |(next_st.irq_status & next_st.irq_mask);

		// trigger is self-clearing: it lives one cycle as sw_pending
		next_st.sw_pending = trig_accept; // R13

		// master reset sequencer
		case (st.state)
			SRC_ST_RUN: begin
				if (any_level) begin // R01
					next_st.state = SRC_ST_CAUSE;
				end else if (st.sw_pending) begin // R01 R13
					next_st.state = SRC_ST_HOLD;
					next_st.hold_cnt = `SRC_HOLD_CYCLES;
				end
			end
			SRC_ST_CAUSE: begin
				if (!any_level) begin
					next_st.state = SRC_ST_HOLD;
					next_st.hold_cnt = `SRC_HOLD_CYCLES;
				end
			end
			SRC_ST_HOLD: begin
				if (any_level) begin
					next_st.state = SRC_ST_CAUSE;
				end else if (st.sw_pending) begin
					// a new trigger during the stretch gets a full stretch of its own
					next_st.hold_cnt = `SRC_HOLD_CYCLES; // R13
				end else if (st.hold_cnt == `SRC_CNT_ONE) begin
					next_st.state = SRC_ST_RUN;
					next_st.hold_cnt = `SRC_CNT_ZERO;
				end else begin
					next_st.hold_cnt = st.hold_cnt - `SRC_CNT_ONE;
				end
			end
			default: begin
				next_st.state = SRC_ST_CAUSE;
			end
		endcase
		next_st.master_system_reset = (next_st.state != SRC_ST_RUN); // R01

		// regulator standby control follows bit 8
		next_st.regulator_sleep_keep_on = next_st.cause[`SRC_BIT_VREG]; // R03

		// read data one cycle after the strobe, zero otherwise
		next_st.rdata = `SRC_ZERO_WORD;
		if (bus.read) begin
			next_st.rdata = read_word(bus.addr, st.cause, st.irq_status, st.irq_mask); // R12 R15
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; reset_n is power-on, the master reset does not clear us

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st <= SRC_POR_STATE; // R09 R10 R16
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		reg_rdata = st.rdata;
		master_system_reset = st.master_system_reset;
		regulator_sleep_keep_on = st.regulator_sleep_keep_on;
		irq = st.irq;
	end

endmodule // src_reset_ctrl

// file: tb/src_reset_ctrl_monitor.sv
module src_reset_ctrl_monitor (
	input wire logic clk_sys,
	input wire logic reset_n,
	input src_pkg::src_causes_t causes,
	input wire logic system_unlocked,
	input src_pkg::src_bus_req_t bus,
	input wire logic [31:0] reg_rdata,
	input wire logic master_system_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	import src_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_trig;
		bus.write && bus.addr == 8'h04 && bus.wdata[0] && system_unlocked;
	endsequence
	sequence s_fall;
		$fell(master_system_reset);
	endsequence
	a_rdata_idle_zero: assert property (!$past(bus.read) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not zero");
	a_cause_gap_zero: assert property ($past(bus.read) && $past(bus.addr) == 8'h00 |-> reg_rdata[31:10] == 22'h0 && !reg_rdata[5])
		else $error("unused cause bits set");
	a_trig_reads_zero: assert property ($past(bus.read) && $past(bus.addr) == 8'h04 |-> reg_rdata == 32'h0000_0000)
		else $error("trigger register read not zero");
	a_pin_forces_reset: assert property (!causes.external_clear_pin_n |=> master_system_reset)
		else $error("pin did not reset");
	a_wdt_forces_reset: assert property (causes.watchdog_timeout |=> master_system_reset)
		else $error("watchdog did not reset");
	a_bor_forces_reset: assert property (causes.brownout || causes.config_mismatch |=> master_system_reset)
		else $error("brownout or mismatch did not reset");
	a_trig_starts_reset: assert property (s_trig |-> ##2 master_system_reset)
		else $error("trigger did not reset");
	a_hold_before_fall: assert property (s_fall |-> $past(master_system_reset, 16))
		else $error("master reset released early");
endmodule // src_reset_ctrl_monitor

bind src_reset_ctrl src_reset_ctrl_monitor mon (.clk_sys(clk_sys), .reset_n(reset_n), .causes(causes),
	.system_unlocked(system_unlocked), .bus(bus), .reg_rdata(reg_rdata), .master_system_reset(master_system_reset));

// file: tb/src_cause_model.sv
module src_cause_model (
	input wire logic [3:0] hold_req,
	input wire logic [1:0] wake_req,
	output src_pkg::src_causes_t causes
);
	timeunit 1ns;
	timeprecision 1ps;
	import src_pkg::*;
	// detectors hold a level for as long as they want reset; the pin is active low
	assign causes = {!hold_req[0], hold_req[1], hold_req[2], hold_req[3], wake_req};
endmodule // src_cause_model

// file: tb/tb_src_reset_ctrl.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t got %h want %h", $time, (a), (b)); end end
module tb_src_reset_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import src_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic system_unlocked = 1'b0;
	logic [3:0] hold_req = 4'h0;
	logic [1:0] wake_req = 2'h0;
	src_bus_req_t bus = '0;
	src_causes_t causes;
	logic [31:0] reg_rdata;
	logic master_system_reset;
	logic regulator_sleep_keep_on;
	logic irq;
	int fail_count = 0;
	int compares = 0;
	always #4 clk_sys = ~clk_sys;
	src_cause_model model (.hold_req(hold_req), .wake_req(wake_req), .causes(causes));
	src_reset_ctrl uut (.clk_sys(clk_sys), .reset_n(reset_n), .causes(causes), .system_unlocked(system_unlocked),
		.bus(bus), .reg_rdata(reg_rdata), .master_system_reset(master_system_reset),
		.regulator_sleep_keep_on(regulator_sleep_keep_on), .irq(irq));
	////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) bus <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys) bus <= '0;
		#1 `CHK(reg_rdata, e)
	endtask
	// bounded wait; a hang ends the run
	task wait_low;
		int i;
		for (i = 0; i < 64 && master_system_reset !== 1'b0; i++) @(negedge clk_sys);
		if (i == 64) begin
			fail_count++;
			tally_and_finish;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset_values;
		wait_low;
		rd(8'h00, 32'h0000_0003);
		rd(8'h04, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		wr(8'h00, 32'hFFFF_FFFF);
		rd(8'h00, 32'h0000_03DF);
		`CHK(regulator_sleep_keep_on, 1'b1)
		wr(8'h00, 32'h0000_0000);
		rd(8'h00, 32'h0000_0000);
		`CHK(regulator_sleep_keep_on, 1'b0)
	endtask
	task t_level_causes;
		static int bits[4] = '{7, 4, 1, 9};
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys) hold_req <= 4'h1 << k;
			repeat (3) @(negedge clk_sys);
			`CHK(master_system_reset, 1'b1)
			wr(8'h00, 32'h0000_0000);
			rd(8'h00, 32'h1 << bits[k]);
			@(posedge clk_sys) hold_req <= 4'h0;
			wait_low;
			rd(8'h00, 32'h1 << bits[k]);
			wr(8'h00, 32'h0000_0000);
		end
	endtask
	task t_software;
		wr(8'h04, 32'h0000_0001);
		repeat (4) @(negedge clk_sys);
		`CHK(master_system_reset, 1'b0)
		@(posedge clk_sys) system_unlocked <= 1'b1;
		wr(8'h04, 32'h0000_0000);
		repeat (3) @(negedge clk_sys);
		`CHK(master_system_reset, 1'b0)
		wr(8'h04, 32'h0000_0001);
		repeat (3) @(negedge clk_sys);
		`CHK(master_system_reset, 1'b1)
		wait_low;
		rd(8'h00, 32'h0000_0040);
		rd(8'h04, 32'h0000_0000);
		@(posedge clk_sys) system_unlocked <= 1'b0;
		wr(8'h00, 32'h0000_0000);
	endtask
	task t_wake_irq;
		wr(8'h08, 32'hFFFF_FFFF);
		wr(8'h0C, 32'h0000_0008);
		@(posedge clk_sys) wake_req <= 2'b10;
		@(posedge clk_sys) wake_req <= 2'b01;
		@(posedge clk_sys) wake_req <= 2'b00;
		repeat (3) @(negedge clk_sys);
		`CHK(irq, 1'b1)
		`CHK(master_system_reset, 1'b0)
		rd(8'h00, 32'h0000_000C);
		rd(8'h08, 32'h0000_000C);
		wr(8'h0C, 32'h0000_0000);
		repeat (2) @(negedge clk_sys);
		`CHK(irq, 1'b0)
		wr(8'h0C, 32'h0000_0008);
		repeat (2) @(negedge clk_sys);
		`CHK(irq, 1'b1)
		wr(8'h08, 32'h0000_0008);
		repeat (2) @(negedge clk_sys);
		`CHK(irq, 1'b0)
		rd(8'h08, 32'h0000_0004);
	endtask
	// power-on again in mid-run: flags and regulator control return to their power-on values
	task t_power_cycle;
		wr(8'h00, 32'h0000_0100);
		@(posedge clk_sys) reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(negedge clk_sys);
		`CHK(master_system_reset, 1'b1)
		`CHK(regulator_sleep_keep_on, 1'b0)
		wait_low;
		rd(8'h00, 32'h0000_0003);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset_values;
		t_level_causes;
		t_software;
		t_wake_irq;
		t_power_cycle;
		tally_and_finish;
	end
endmodule // tb_src_reset_ctrl
